// >>> common/spbc_pkg.sv
// constants, field layout and shared helpers for the set-point mode and burst control block
`default_nettype none
package spbc_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 6;
	localparam int VAR_W  = 16;
	localparam int NVARS  = 4;
	localparam int CTRL_W = 12;

	localparam logic [ADDR_W-1:0] OFS_CTRL     = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h0c;
	localparam logic [ADDR_W-1:0] OFS_INFO_EN  = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_ALERT_EN = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_LINK_SP  = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_BURST    = 6'h1c;

	localparam int CTRL_MODE    = 0;
	localparam int CTRL_RESTART = 2;
	localparam int CTRL_BEN     = 4;
	localparam int CTRL_BCMD    = 5;
	localparam int CTRL_PSEL    = 7;
	localparam int CTRL_PROT    = 9;
	localparam int CTRL_AUXCAL  = 10;
	localparam int CTRL_PROMPT  = 11;
	localparam logic [CTRL_W-1:0] CTRL_RST = 12'h240;

	localparam logic [1:0] MODE_ANALOG     = 2'h0;
	localparam logic [1:0] MODE_DIGITAL    = 2'h1;
	localparam logic [1:0] MODE_TEST       = 2'h2;
	localparam logic [1:0] RESTART_RESUME  = 2'h0;
	localparam logic [1:0] RESTART_ANALOG  = 2'h1;
	localparam logic [1:0] RESTART_DIGITAL = 2'h2;
	localparam logic [1:0] BCMD_U1  = 2'h0;
	localparam logic [1:0] BCMD_U2  = 2'h1;
	localparam logic [1:0] BCMD_U3  = 2'h2;
	localparam logic [1:0] BCMD_DEV = 2'h3;
	localparam logic [7:0] CMD_NUM_U1  = 8'h01;
	localparam logic [7:0] CMD_NUM_U2  = 8'h02;
	localparam logic [7:0] CMD_NUM_U3  = 8'h03;
	localparam logic [7:0] CMD_NUM_DEV = 8'h94;
	localparam logic [1:0] PSEL_A    = 2'h0;
	localparam logic [1:0] PSEL_B    = 2'h1;
	localparam logic [1:0] PSEL_DIFF = 2'h2;
	localparam logic [1:0] PSEL_SUP  = 2'h3;
	localparam logic       PROT_NONE = 1'b0;

	localparam int IRQ_W       = 5;
	localparam int IRQ_FRAME   = 0;
	localparam int IRQ_SERVED  = 1;
	localparam int IRQ_REJECT  = 2;
	localparam int IRQ_AUTOCAL = 3;
	localparam int IRQ_MODE    = 4;

	localparam int INFO_EN_W  = 9;
	localparam int ALERT_EN_W = 5;
	localparam logic [INFO_EN_W-1:0]  INFO_EN_RST  = 9'h0f0;
	localparam logic [ALERT_EN_W-1:0] ALERT_EN_RST = 5'h0b;

	localparam int CLK_NS  = 25;
	localparam int GAP_NS  = 20000;
	localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [3:0] {
		BST_IDLE  = 4'b0001,
		BST_SEND  = 4'b0010,
		BST_GAP   = 4'b0100,
		BST_SERVE = 4'b1000
	} spbc_bst_t;

	function automatic logic [7:0] cmd_number(input logic [1:0] sel);
		case (sel)
			BCMD_U1: cmd_number = CMD_NUM_U1;
			BCMD_U2: cmd_number = CMD_NUM_U2;
			BCMD_U3: cmd_number = CMD_NUM_U3;
			default: cmd_number = CMD_NUM_DEV;
		endcase
	endfunction

	function automatic logic [2:0] cmd_nvars(input logic [1:0] sel);
		case (sel)
			BCMD_U1: cmd_nvars = 3'h1;
			BCMD_U2: cmd_nvars = 3'h2;
			default: cmd_nvars = 3'h4;
		endcase
	endfunction
endpackage
`default_nettype wire

// >>> hdl/spbc_sync.sv
// two-stage synchroniser for levels arriving from pins
`timescale 1ns/1ps
`default_nettype none
module spbc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,    // system clock
	input  wire logic         rst,    // synchronous reset
	input  wire logic [W-1:0] d,      // asynchronous level
	output logic      [W-1:0] q       // synchronised level
);
	logic [W-1:0] meta;

	always_ff @(posedge clk)
	begin
		meta <= rst ? '0 : d;
		q    <= rst ? '0 : meta;
	end
endmodule
`default_nettype wire

// >>> hdl/spbc_burst.sv
// burst frame sequencer with inter-frame gap and request service
`timescale 1ns/1ps
`default_nettype none
module spbc_burst
	import spbc_pkg::*;
#(
	parameter int GAP = GAP_CYC
) (
	input  wire logic                   clk,         // system clock
	input  wire logic                   rst,         // synchronous reset
	input  wire logic                   burst_en,    // burst enabled
	input  wire logic [7:0]             cmd_num,     // command number in header
	input  wire logic [2:0]             nvars,       // variables in frame
	input  wire logic [NVARS*VAR_W-1:0] vars,        // variables, first in low bits
	input  wire logic                   req_start,   // master request seen
	input  wire logic                   resp_done,   // response sent
	input  wire logic                   tx_ready,    // link accepts word
	output logic                        tx_valid,    // word offered
	output logic      [VAR_W-1:0]       tx_data,     // word
	output logic                        tx_last,     // last word of frame
	output logic                        frame_done,  // frame finished pulse
	output logic                        served,      // request answered pulse
	output logic                        req_pending, // request waiting
	output spbc_bst_t                   state        // sequencer state
);
	logic [NVARS*VAR_W-1:0] snap;
	logic [2:0]             idx;
	logic [15:0]            gap_cnt;
	wire                    take   = tx_valid && tx_ready;
	wire                    launch = burst_en && !req_pending && (state == BST_IDLE
	                                 || (state == BST_GAP && gap_cnt == 16'h0000));
	wire                    at_end = (idx == nvars);

	assign tx_valid = (state == BST_SEND);

	always_ff @(posedge clk)
	begin
		if (rst || !burst_en)
			req_pending <= 1'b0;
		else if (req_start)
			req_pending <= 1'b1;
		else if (state == BST_SERVE && resp_done)
			req_pending <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		frame_done <= 1'b0;
		served     <= 1'b0;
		if (rst)
		begin
			state   <= BST_IDLE;
			idx     <= 3'h0;
			gap_cnt <= 16'h0000;
			tx_data <= 16'h0000;
			tx_last <= 1'b0;
			snap    <= '0;
		end
		else
		begin
			case (state)
				BST_IDLE, BST_GAP:
				begin
					if (gap_cnt != 16'h0000)
						gap_cnt <= gap_cnt - 16'h0001;
					if (launch)
					begin
						state   <= BST_SEND;
						idx     <= 3'h0;
						snap    <= vars;
						tx_data <= {8'h00, cmd_num};
						tx_last <= 1'b0;
					end
					else if (state == BST_GAP && req_pending)
						state <= BST_SERVE;
					else if (!burst_en)
						state <= BST_IDLE;
				end
				BST_SEND:
				begin
					if (take && at_end)
					begin
						state      <= BST_GAP;
						gap_cnt    <= 16'(GAP);
						frame_done <= 1'b1;
						tx_last    <= 1'b0;
					end
					else if (take)
					begin
						tx_data <= snap[idx*VAR_W +: VAR_W];
						tx_last <= (idx + 3'h1 == nvars);
						idx     <= idx + 3'h1;
					end
				end
				BST_SERVE:
				begin
					if (resp_done || !burst_en)
					begin
						state   <= BST_GAP;
						gap_cnt <= 16'(GAP);
						served  <= resp_done;
					end
				end
				default:
					state <= BST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> hdl/spbc_top.sv
// set-point source, restart mode, burst and protection control with Avalon-MM registers
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module spbc_top
	import spbc_pkg::*;
#(
	parameter int GAP = GAP_CYC
) (
	input  wire logic              CLK_SYS,          // 40 MHz system clock
	input  wire logic              RST,              // synchronous reset, active high
	input  wire logic [ADDR_W-1:0] AVS_ADDRESS,      // byte address
	input  wire logic              AVS_READ,         // read request
	input  wire logic              AVS_WRITE,        // write request
	input  wire logic [DATA_W-1:0] AVS_WRITEDATA,    // write data
	input  wire logic [3:0]        AVS_BYTEENABLE,   // byte lanes
	output logic      [DATA_W-1:0] AVS_READDATA,     // read data
	output logic                   AVS_WAITREQUEST,  // stall
	output logic                   IRQ,              // level interrupt
	input  wire logic [VAR_W-1:0]  LOOP_SP,          // set point from loop current converter
	input  wire logic [VAR_W-1:0]  AIN,              // analog input variable
	input  wire logic [VAR_W-1:0]  TRAVEL,           // measured travel
	input  wire logic [VAR_W-1:0]  PRESS_A,          // output A pressure
	input  wire logic [VAR_W-1:0]  PRESS_B,          // output B pressure
	input  wire logic [VAR_W-1:0]  PRESS_SUP,        // supply pressure
	output logic      [VAR_W-1:0]  SETPOINT,         // valve set point
	output logic      [1:0]        MODE,             // active set-point source
	input  wire logic              AUX_JUMPER,       // auxiliary terminal jumper pin
	output logic                   PROTECTED,        // config and calibration protected
	output logic                   AUTOCAL_START,    // start travel calibration pulse
	input  wire logic [1:0]        NV_LAST_MODE,     // stored last mode
	input  wire logic [1:0]        NV_RESTART,       // stored restart setting
	output logic                   NV_WR,            // store strobe
	output logic      [3:0]        NV_WDATA,         // restart setting and last mode
	input  wire logic              LINK_REQ,         // master request start pulse
	input  wire logic              LINK_RESP_DONE,   // response sent pulse
	input  wire logic              TX_READY,         // link accepts word
	output logic                   TX_VALID,         // burst word offered
	output logic      [VAR_W-1:0]  TX_DATA,          // burst word
	output logic                   TX_LAST           // last burst word
);
	function automatic logic [DATA_W-1:0] merge_be(input logic [DATA_W-1:0] old,
	                                               input logic [DATA_W-1:0] wd,
	                                               input logic [3:0]        be);
		logic [DATA_W-1:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		merge_be = r;
	endfunction

	logic [CTRL_W-1:0]     ctrl;
	logic [IRQ_W-1:0]      irq_stat;
	logic [IRQ_W-1:0]      irq_mask;
	logic [INFO_EN_W-1:0]  info_en;
	logic [ALERT_EN_W-1:0] alert_en;
	logic [VAR_W-1:0]      link_sp;
	logic                  ack;
	logic                  boot_done;
	logic                  jumper;
	logic                  jumper_prev;
	logic [3:0]            nv_shadow;
	logic [15:0]           frame_cnt;
	logic                  frame_done;
	logic                  served;
	logic                  req_pending;
	spbc_bst_t             bst_state;

	// bus decode; a write lands only at the edge where waitrequest is seen low
	wire                   access   = (AVS_READ || AVS_WRITE) && !ack;
	wire                   wr       = AVS_WRITE && ack;
	wire                   hit_ctrl = (AVS_ADDRESS == OFS_CTRL);
	wire                   hit_irqs = (AVS_ADDRESS == OFS_IRQ_STAT);
	wire                   hit_irqm = (AVS_ADDRESS == OFS_IRQ_MASK);
	wire                   hit_info = (AVS_ADDRESS == OFS_INFO_EN);
	wire                   hit_alrt = (AVS_ADDRESS == OFS_ALERT_EN);
	wire                   hit_lsp  = (AVS_ADDRESS == OFS_LINK_SP);
	wire [DATA_W-1:0]      wdata    = merge_be({20'h00000, ctrl}, AVS_WRITEDATA, AVS_BYTEENABLE);

	// requested control fields
	wire [1:0]             req_mode    = wdata[CTRL_MODE +: 2];
	wire [1:0]             req_restart = wdata[CTRL_RESTART +: 2];
	wire                   req_ben     = wdata[CTRL_BEN];
	wire [1:0]             req_bcmd    = wdata[CTRL_BCMD +: 2];
	wire                   req_prot    = wdata[CTRL_PROT];
	wire                   ctrl_wr     = wr && hit_ctrl;

	wire [1:0]             cur_mode    = ctrl[CTRL_MODE +: 2];
	wire [1:0]             cur_restart = ctrl[CTRL_RESTART +: 2];
	wire                   cur_ben     = ctrl[CTRL_BEN];
	wire [1:0]             cur_bcmd    = ctrl[CTRL_BCMD +: 2];
	wire [1:0]             cur_psel    = ctrl[CTRL_PSEL +: 2];
	wire                   cur_prot    = ctrl[CTRL_PROT];

	// only the three mode codes are taken; test holds until analog or digital is written
	wire                   mode_ok     = (req_mode != 2'h3);
	wire                   restart_ok  = (req_restart != 2'h3);
	// command change needs burst already enabled
	wire                   bcmd_ok     = cur_ben || (req_bcmd == cur_bcmd);
	wire                   prot_ok     = (req_prot != PROT_NONE) || jumper || (cur_prot == PROT_NONE);
	wire                   reject      = ctrl_wr && !(mode_ok && restart_ok && bcmd_ok && prot_ok);
	wire                   mode_chg    = ctrl_wr && mode_ok && (req_mode != cur_mode);

	// restart selection, falling back to analog for an unusable stored mode
	wire [1:0]             resume_mode = (NV_LAST_MODE == 2'h3) ? MODE_ANALOG : NV_LAST_MODE;
	wire [1:0]             boot_mode   = (NV_RESTART == RESTART_ANALOG)  ? MODE_ANALOG :
	                                     (NV_RESTART == RESTART_DIGITAL) ? MODE_DIGITAL : resume_mode;
	wire [1:0]             boot_rst    = (NV_RESTART == 2'h3) ? RESTART_RESUME : NV_RESTART;

	// pressure chosen for the third variable
	wire [VAR_W-1:0]       press_sel   = (cur_psel == PSEL_A)    ? PRESS_A :
	                                     (cur_psel == PSEL_B)    ? PRESS_B :
	                                     (cur_psel == PSEL_DIFF) ? VAR_W'(PRESS_A - PRESS_B) : PRESS_SUP;
	// set-point source; test strokes from link values too
	wire [VAR_W-1:0]       next_sp     = (cur_mode == MODE_ANALOG) ? LOOP_SP : link_sp;
	// variable order: analog input, travel target, pressure, travel
	wire [NVARS*VAR_W-1:0] burst_vars  = {TRAVEL, press_sel, SETPOINT, AIN};

	// early jumper removal with the auto-calibration action armed
	wire                   jumper_fell = jumper_prev && !jumper;
	wire                   autocal     = ctrl[CTRL_AUXCAL] && !ctrl[CTRL_PROMPT] && jumper_fell;

	wire [IRQ_W-1:0]       irq_events  = {mode_chg, autocal, reject, served, frame_done};
	wire [IRQ_W-1:0]       irq_clr     = (wr && hit_irqs) ? AVS_WRITEDATA[IRQ_W-1:0] : '0;

	wire [DATA_W-1:0]      status_word = {14'h0000, bst_state, req_pending, boot_done,
	                                      cur_prot, jumper, 8'h00, cur_mode};
	wire [DATA_W-1:0]      burst_word  = {frame_cnt, 8'h00, cmd_number(cur_bcmd)};
	wire [DATA_W-1:0]      rd_mux      = (AVS_ADDRESS == OFS_CTRL)     ? {20'h00000, ctrl} :
	                                     (AVS_ADDRESS == OFS_STATUS)   ? status_word :
	                                     (AVS_ADDRESS == OFS_IRQ_STAT) ? {27'h0000000, irq_stat} :
	                                     (AVS_ADDRESS == OFS_IRQ_MASK) ? {27'h0000000, irq_mask} :
	                                     (AVS_ADDRESS == OFS_INFO_EN)  ? {23'h000000, info_en} :
	                                     (AVS_ADDRESS == OFS_ALERT_EN) ? {27'h0000000, alert_en} :
	                                     (AVS_ADDRESS == OFS_LINK_SP)  ? {16'h0000, link_sp} :
	                                     (AVS_ADDRESS == OFS_BURST)    ? burst_word : 32'h00000000;

	// every access waits exactly one cycle so read data come from a register
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
	assign IRQ             = |(irq_stat & irq_mask);
	assign MODE            = cur_mode;
	assign PROTECTED       = cur_prot;

	spbc_sync #(
		.W (1)
	) u_jumper_sync (
		.clk (CLK_SYS),
		.rst (RST),
		.d   (AUX_JUMPER),
		.q   (jumper)
	);

	spbc_burst #(
		.GAP (GAP)
	) u_burst (
		.clk         (CLK_SYS),
		.rst         (RST),
		.burst_en    (cur_ben && boot_done),
		.cmd_num     (cmd_number(cur_bcmd)),
		.nvars       (cmd_nvars(cur_bcmd)),
		.vars        (burst_vars),
		.req_start   (LINK_REQ),
		.resp_done   (LINK_RESP_DONE),
		.tx_ready    (TX_READY),
		.tx_valid    (TX_VALID),
		.tx_data     (TX_DATA),
		.tx_last     (TX_LAST),
		.frame_done  (frame_done),
		.served      (served),
		.req_pending (req_pending),
		.state       (bst_state)
	);

	always_ff @(posedge CLK_SYS)
	begin
		ack          <= RST ? 1'b0 : access;
		AVS_READDATA <= RST ? 32'h00000000 : rd_mux;
	end

	// control register; the stored values are taken once, one cycle after reset release
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			ctrl      <= CTRL_RST;
			boot_done <= 1'b0;
		end
		else if (!boot_done)
		begin
			ctrl[CTRL_MODE +: 2]    <= boot_mode;
			ctrl[CTRL_RESTART +: 2] <= boot_rst;
			boot_done               <= 1'b1;
		end
		else if (ctrl_wr)
		begin
			if (mode_ok)
				ctrl[CTRL_MODE +: 2] <= req_mode;
			if (restart_ok)
				ctrl[CTRL_RESTART +: 2] <= req_restart;
			ctrl[CTRL_BEN] <= req_ben;
			if (bcmd_ok)
				ctrl[CTRL_BCMD +: 2] <= req_bcmd;
			ctrl[CTRL_PSEL +: 2] <= wdata[CTRL_PSEL +: 2];
			if (prot_ok)
				ctrl[CTRL_PROT] <= req_prot;
			ctrl[CTRL_AUXCAL] <= wdata[CTRL_AUXCAL];
			ctrl[CTRL_PROMPT] <= wdata[CTRL_PROMPT];
		end
	end

	// enables for informational status and alert record, interrupt mask and link set point
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			info_en  <= INFO_EN_RST;
			alert_en <= ALERT_EN_RST;
			irq_mask <= '0;
			link_sp  <= 16'h0000;
		end
		else if (wr)
		begin
			if (hit_info)
				info_en <= AVS_WRITEDATA[INFO_EN_W-1:0];
			if (hit_alrt)
				alert_en <= AVS_WRITEDATA[ALERT_EN_W-1:0];
			if (hit_irqm)
				irq_mask <= AVS_WRITEDATA[IRQ_W-1:0];
			// set point delivered over the link
			if (hit_lsp)
				link_sp <= AVS_WRITEDATA[VAR_W-1:0];
		end
	end

	// sticky events: a set in the same cycle as its clear wins
	always_ff @(posedge CLK_SYS)
	begin
		irq_stat <= RST ? '0 : ((irq_stat & ~irq_clr) | irq_events);
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			SETPOINT      <= 16'h0000;
			jumper_prev   <= 1'b0;
			AUTOCAL_START <= 1'b0;
			frame_cnt     <= 16'h0000;
		end
		else
		begin
			SETPOINT      <= next_sp;
			jumper_prev   <= jumper;
			AUTOCAL_START <= autocal;
			if (frame_done)
				frame_cnt <= frame_cnt + 16'h0001;
		end
	end

	// the nonvolatile copy follows the active mode; writing only on change spares endurance
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			nv_shadow <= 4'h0;
			NV_WR     <= 1'b0;
			NV_WDATA  <= 4'h0;
		end
		else if (!boot_done)
		begin
			nv_shadow <= {boot_rst, boot_mode};
			NV_WR     <= 1'b0;
		end
		else
		begin
			nv_shadow <= {cur_restart, cur_mode};
			NV_WR     <= ({cur_restart, cur_mode} != nv_shadow);
			NV_WDATA  <= {cur_restart, cur_mode};
		end
	end
endmodule
`default_nettype wire

// >>> bench/spbc_chk.sv
// concurrent checks on the control block's ports
`timescale 1ns/1ps
`default_nettype none
module spbc_chk
	import spbc_pkg::*;
#(
	parameter int GAP = GAP_CYC
) (
	input wire logic             CLK_SYS,         // clock
	input wire logic             RST,             // reset
	input wire logic             AVS_READ,        // read
	input wire logic             AVS_WRITE,       // write
	input wire logic             AVS_WAITREQUEST, // stall
	input wire logic [VAR_W-1:0] LOOP_SP,         // loop set point
	input wire logic [VAR_W-1:0] SETPOINT,        // set point
	input wire logic [1:0]       MODE,            // source mode
	input wire logic             AUX_JUMPER,      // jumper pin
	input wire logic             PROTECTED,       // protection
	input wire logic             AUTOCAL_START,   // calibration pulse
	input wire logic             NV_WR,           // store strobe
	input wire logic [3:0]       NV_WDATA,        // stored data
	input wire logic             TX_READY,        // word taken
	input wire logic             TX_VALID,        // word offered
	input wire logic [VAR_W-1:0] TX_DATA,         // word
	input wire logic             TX_LAST          // last word
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	sequence s_take_last;
		TX_VALID && TX_READY && TX_LAST;
	endsequence
	sequence s_gap;
		!TX_VALID [*3];
	endsequence
	a_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("bus stall longer than one cycle");
	// reset edge excluded: the update at release still saw reset
	a_sp_analog: assert property (!RST && MODE == MODE_ANALOG |=> SETPOINT == $past(LOOP_SP))
		else $error("set point not from loop");
	a_mode_code: assert property (MODE != 2'h3)
		else $error("undefined source mode");
	a_word_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
		else $error("burst word changed under stall");
	a_frame_gap: assert property (s_take_last |=> s_gap)
		else $error("no gap after frame");
	a_last_word: assert property ($fell(TX_VALID) |-> $past(TX_LAST))
		else $error("frame ended without last flag");
	a_hdr_cmd: assert property ($rose(TX_VALID) |-> TX_DATA inside {16'h0001, 16'h0002, 16'h0003, 16'h0094})
		else $error("bad burst header");
	a_prot_jumper: assert property ($fell(PROTECTED) |-> $past(AUX_JUMPER, 3))
		else $error("protection dropped without jumper");
	a_cal_pulse: assert property (AUTOCAL_START |-> !AUX_JUMPER ##1 !AUTOCAL_START)
		else $error("bad calibration start");
	a_nv_mode: assert property (NV_WR |-> NV_WDATA[1:0] == MODE ##1 !NV_WR)
		else $error("bad mode store");
endmodule
bind spbc_top spbc_chk #(.GAP(GAP)) u_chk (.*);
`default_nettype wire

// >>> bench/spbc_master.sv
// link master model: paced word acceptance and polled requests
`timescale 1ns/1ps
`default_nettype none
module spbc_master (
	input  wire logic clk,                   // clock
	input  wire logic rst,                   // reset
	input  wire logic go,                    // start a request
	output logic      tx_ready = 1'b0,       // accepts word
	output logic      link_req = 1'b0,       // request pulse
	output logic      link_resp_done = 1'b0  // response pulse
);
	int wait_cnt = 0;
	always @(posedge clk)
	begin
		tx_ready <= !rst && ($urandom_range(3) != 0);
		link_req <= go && !rst;
		link_resp_done <= (wait_cnt == 1);
		if (rst)
			wait_cnt <= 0;
		else if (go)
			wait_cnt <= 30;
		else if (wait_cnt > 0)
			wait_cnt <= wait_cnt - 1;
	end
endmodule
`default_nettype wire

// >>> bench/setpoint_mode_burst_control_bench.sv
// self-checking bench for the set-point mode and burst control block
`timescale 1ns/1ps
`default_nettype none
module setpoint_mode_burst_control_bench
	import spbc_pkg::*;
;
	logic CLK_SYS, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ, AUX_JUMPER, PROTECTED, AUTOCAL_START;
	logic NV_WR, LINK_REQ, LINK_RESP_DONE, TX_READY, TX_VALID, TX_LAST, go;
	logic [ADDR_W-1:0] AVS_ADDRESS;
	logic [DATA_W-1:0] AVS_WRITEDATA, AVS_READDATA, rd;
	logic [3:0]        AVS_BYTEENABLE, NV_WDATA;
	logic [VAR_W-1:0]  LOOP_SP, AIN, TRAVEL, PRESS_A, PRESS_B, PRESS_SUP, SETPOINT, TX_DATA, sp;
	logic [1:0]        MODE, NV_LAST_MODE, NV_RESTART, prev;
	logic [7:0]        cnum[4] = '{8'h01, 8'h02, 8'h03, 8'h94};
	int                nv[4] = '{1, 2, 4, 4};
	logic [15:0]       words[$];
	int                bad_count, samples_checked, i, j;
	spbc_top #(.GAP(4)) u_dut (.*);
	spbc_master u_mst (.clk(CLK_SYS), .rst(RST), .go(go), .tx_ready(TX_READY), .link_req(LINK_REQ),
		.link_resp_done(LINK_RESP_DONE));
	initial
	begin
		CLK_SYS = 0;
		forever #12.5 CLK_SYS = ~CLK_SYS;
	end
	// words are counted where both handshake sides are settled
	always @(negedge CLK_SYS)
		if (TX_VALID && TX_READY)
			words.push_back(TX_DATA);
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
		samples_checked++;
		if (s !== e)
		begin
			bad_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge CLK_SYS);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		// waitrequest and read data are read at the rising edge, before that edge's updates land
		@(posedge CLK_SYS);
		while (AVS_WAITREQUEST !== 1'b0)
			@(posedge CLK_SYS);
		rd = AVS_READDATA;
		AVS_WRITE <= 0;
		AVS_READ <= 0;
		// the accepted write updates at that edge; callers look one edge later
		@(posedge CLK_SYS);
	endtask
	function automatic logic [31:0] ctl(input logic [1:0] md, input logic ben, input logic [1:0] bc,
		input logic [1:0] ps, input logic pr, input logic ax);
		ctl = {21'h0, ax, pr, ps, bc, ben, RESTART_DIGITAL, md};
	endfunction
	function automatic logic [15:0] exp_var(input int k, input logic [1:0] ps);
		case (k)
			0: exp_var = AIN;
			1: exp_var = LOOP_SP;
			2: exp_var = (ps == PSEL_A) ? PRESS_A : (ps == PSEL_B) ? PRESS_B : (ps == PSEL_DIFF) ? PRESS_A - PRESS_B : PRESS_SUP;
			default: exp_var = TRAVEL;
		endcase
	endfunction
	task automatic rnd;
		LOOP_SP <= $urandom;
		AIN <= $urandom;
		TRAVEL <= $urandom;
		PRESS_A <= $urandom;
		PRESS_B <= $urandom;
		PRESS_SUP <= $urandom;
	endtask
	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge CLK_SYS);
		bad_count++;
		report_and_stop();
	end
	initial
	begin
		void'($urandom(32'hc1df));
		{RST, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, AUX_JUMPER, go} = 1'b1 << (DATA_W + ADDR_W + 4);
		AVS_BYTEENABLE = 4'hf;
		NV_LAST_MODE = MODE_ANALOG;
		NV_RESTART = RESTART_DIGITAL;
		bad_count = 0;
		samples_checked = 0;
		sp = $urandom;
		prev = BCMD_U3;
		rnd();
		repeat (12) @(posedge CLK_SYS);
		RST <= 0;
		repeat (3) @(posedge CLK_SYS);
		chk(MODE, MODE_DIGITAL, "restart mode");
		bus(0, OFS_INFO_EN, 0);
		chk(rd, 32'h0f0, "status enables");
		bus(0, OFS_ALERT_EN, 0);
		chk(rd, 32'h0b, "record enables");
		bus(0, 6'h3c, 0);
		chk(rd, 0, "unmapped read");
		bus(1, OFS_LINK_SP, {16'h0, sp});
		repeat (2) @(posedge CLK_SYS);
		chk(SETPOINT, sp, "link set point");
		bus(1, OFS_CTRL, ctl(MODE_ANALOG, 0, BCMD_U3, PSEL_A, 1, 0));
		repeat (2) @(posedge CLK_SYS);
		chk(SETPOINT, LOOP_SP, "loop set point");
		chk(NV_WDATA, {RESTART_DIGITAL, MODE_ANALOG}, "stored mode");
		bus(1, OFS_CTRL, ctl(MODE_TEST, 0, BCMD_U3, PSEL_A, 1, 0));
		bus(1, OFS_CTRL, ctl(2'h3, 0, BCMD_U3, PSEL_A, 1, 0));
		chk(MODE, MODE_TEST, "test mode kept");
		bus(1, OFS_IRQ_MASK, 32'h4);
		chk(IRQ, 1, "reject interrupt");
		bus(1, OFS_IRQ_STAT, 32'h1f);
		chk(IRQ, 0, "interrupt cleared");
		bus(1, OFS_CTRL, ctl(MODE_ANALOG, 0, BCMD_U1, PSEL_A, 1, 0));
		bus(0, OFS_BURST, 0);
		chk(rd[7:0], 8'h03, "command kept while disabled");
		for (i = 0; i < 4; i++)
		begin
			bus(1, OFS_CTRL, ctl(MODE_ANALOG, 1, prev, i[1:0], 1, 0));
			bus(1, OFS_CTRL, ctl(MODE_ANALOG, 1, i[1:0], i[1:0], 1, 0));
			bus(1, OFS_CTRL, ctl(MODE_ANALOG, 0, i[1:0], i[1:0], 1, 0));
			repeat (20) @(posedge CLK_SYS);
			words.delete();
			rnd();
			repeat (2) @(posedge CLK_SYS);
			bus(1, OFS_CTRL, ctl(MODE_ANALOG, 1, i[1:0], i[1:0], 1, 0));
			bus(0, OFS_BURST, 0);
			chk(rd[7:0], cnum[i], "selected command");
			repeat (40) @(posedge CLK_SYS);
			chk(words[0], {8'h00, cnum[i]}, "frame header");
			for (j = 0; j < nv[i]; j++)
				chk(words[j + 1], exp_var(j, i[1:0]), "frame variable");
			chk(words[nv[i] + 1], {8'h00, cnum[i]}, "repeated frame");
			prev = i[1:0];
		end
		bus(1, OFS_IRQ_STAT, 32'h1f);
		@(posedge CLK_SYS);
		go <= 1;
		@(posedge CLK_SYS);
		go <= 0;
		repeat (60) @(posedge CLK_SYS);
		j = words.size();
		bus(0, OFS_IRQ_STAT, 0);
		chk(rd[1], 1, "request served");
		repeat (20) @(posedge CLK_SYS);
		chk(words.size() > j, 1, "bursting resumed");
		bus(1, OFS_CTRL, ctl(MODE_ANALOG, 1, BCMD_DEV, PSEL_SUP, 0, 0));
		chk(PROTECTED, 1, "protection kept");
		AUX_JUMPER <= 1;
		repeat (4) @(posedge CLK_SYS);
		bus(1, OFS_CTRL, ctl(MODE_ANALOG, 1, BCMD_DEV, PSEL_SUP, 0, 0));
		chk(PROTECTED, 0, "protection removed");
		bus(1, OFS_CTRL, ctl(MODE_ANALOG, 1, BCMD_DEV, PSEL_SUP, 0, 1));
		AUX_JUMPER <= 0;
		j = 0;
		while (AUTOCAL_START !== 1'b1 && j < 10)
		begin
			@(negedge CLK_SYS);
			j++;
		end
		chk(AUTOCAL_START, 1, "calibration start");
		report_and_stop();
	end
endmodule
`default_nettype wire
